// >>> hw/efirc_top.sv
// Ethernet front-end interrupt gathering and reset distribution.
// Assumes single-cycle event pulses from the packet processors, all
// synchronous to mclk, and a plain register port master.
// Function
// - Two separate interrupt outputs: receive group and transmit group.
// - Flag receive buffer closed and receive status overflow on receive.
// - Four receive-complete bits, one per pool A to D.
// - Flag no receive buffer when all rings off, full or too small.
// - Flag receive buffers full when all rings off or full.
// - Flag receive buffer ready while a frame waits in the queue.
// - Statistics overflow on transmit; counters maskable by two masks.
// - Flag transmit buffer closed on transmit interrupt.
// - Flag transmit not ready when in-frame descriptor lacks ready flag.
// - Separate transmit complete and transmit failure bits.
// - Flag transmit idle when no frame is available.
// - One status register and one matching enable register.
// - Writing 1 clears a status bit; writing 0 keeps it.
// - Receive and transmit path resets active low, default low.
// - Hard MAC reset active high, default 0, resets MAC and stats.
// - Soft MAC reset active high, default 1, spares programmable parts.
// - Finer MAC resets active high, default 0, each one module.
// - Transmit failure halts transmit until restart bit rises.
`timescale 1ns/1ps
`include "efirc_regs.svh"
module efirc_top
  import efirc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_data_ovf,
  input wire logic rx_sts_ovf,
  input wire logic rx_buf_closed,
  input wire logic rx_frame_done,
  input wire logic [1:0] rx_frame_pool,
  input wire logic rx_buf_search_fail,
  input wire logic [3:0] ring_disabled,
  input wire logic [3:0] ring_full,
  input wire logic [3:0] ring_too_small,
  input wire logic rx_frame_avail,
  input wire logic [63:0] stat_ovf,
  input wire logic tx_buf_closed,
  input wire logic tx_desc_fetch,
  input wire logic tx_frame_active,
  input wire logic tx_desc_hw_ready,
  input wire logic tx_frame_end,
  input wire logic tx_frame_ok,
  input wire logic tx_no_frame,
  output logic rx_irq,
  output logic tx_irq,
  output logic tx_halted,
  output logic rx_rd_rst,
  output logic rx_wr_rst,
  output logic tx_rd_rst,
  output logic tx_wr_rst,
  output logic mac_core_rst,
  output logic mac_prog_rst,
  output logic stat_rst,
  output logic rmii_rst,
  output logic mac_rx_rst,
  output logic mac_txcs_rst,
  output logic mac_tx_rst,
  output logic miim_rst
);

  localparam int NI = `EFIRC_NI;
  function automatic logic [3:0] pool_dec(input logic [1:0] p);
    pool_dec = 4'h1 << p;
  endfunction : pool_dec
  logic receive_path_reset_n_q, transmit_path_reset_n_q;
  logic mac_hard_reset_q, tx_logic_restart_toggle_q, restart_prev_q;
  logic mac_soft_reset_q, mac_rx_function_reset_q;
  logic mac_tx_control_frame_reset_q, mac_tx_function_reset_q;
  logic mgmt_serial_reset_q, reduced_phy_adapter_reset_q;
  logic [31:0] counter_mask_low_q, counter_mask_high_q;
  logic [NI-1:0] sts_q, sts_d, en_q, set, clr;
  logic all_off_full, all_unusable, restart_rise;
  efirc_tx_state_t tx_st_q, tx_st_d;
  wire wr_ctrl = reg_wr && reg_addr == `EFIRC_A_CTRL;
  wire wr_macc = reg_wr && reg_addr == `EFIRC_A_MACC;
  wire wr_sts = reg_wr && reg_addr == `EFIRC_A_STS;

  // Control bits with path resets and restart toggle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      receive_path_reset_n_q <= 1'(`EFIRC_CTRL_RST >> `EFIRC_B_ERX);
      transmit_path_reset_n_q <= 1'(`EFIRC_CTRL_RST >> `EFIRC_B_ETX);
      mac_hard_reset_q <= 1'(`EFIRC_CTRL_RST >> `EFIRC_B_HRST);
      tx_logic_restart_toggle_q <= 1'(`EFIRC_CTRL_RST >> `EFIRC_B_TCLR);
    end else if (wr_ctrl) begin
      receive_path_reset_n_q <= reg_wdata[`EFIRC_B_ERX];
      transmit_path_reset_n_q <= reg_wdata[`EFIRC_B_ETX];
      mac_hard_reset_q <= reg_wdata[`EFIRC_B_HRST];
      tx_logic_restart_toggle_q <= reg_wdata[`EFIRC_B_TCLR];
    end
  end

  // MAC reset word: soft reset comes up asserted
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mac_soft_reset_q <= 1'(`EFIRC_MACC_RST >> `EFIRC_B_MAC_SOFT_RESET);
      mac_rx_function_reset_q <= 1'(`EFIRC_MACC_RST >> `EFIRC_B_RXF);
      mac_tx_control_frame_reset_q <= 1'(`EFIRC_MACC_RST >> `EFIRC_B_TCS);
      mac_tx_function_reset_q <= 1'(`EFIRC_MACC_RST >> `EFIRC_B_TXF);
      mgmt_serial_reset_q <= 1'(`EFIRC_MACC_RST >> `EFIRC_B_MIIM);
      reduced_phy_adapter_reset_q <= 1'(`EFIRC_MACC_RST >> `EFIRC_B_RMII);
    end else if (wr_macc) begin
      mac_soft_reset_q <= reg_wdata[`EFIRC_B_MAC_SOFT_RESET];
      mac_rx_function_reset_q <= reg_wdata[`EFIRC_B_RXF];
      mac_tx_control_frame_reset_q <= reg_wdata[`EFIRC_B_TCS];
      mac_tx_function_reset_q <= reg_wdata[`EFIRC_B_TXF];
      mgmt_serial_reset_q <= reg_wdata[`EFIRC_B_MIIM];
      reduced_phy_adapter_reset_q <= reg_wdata[`EFIRC_B_RMII];
    end
  end

  // Enables and statistics counter masks (1 masks a counter)
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      en_q <= '0;
      counter_mask_low_q <= '0;
      counter_mask_high_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `EFIRC_A_EN) en_q <= reg_wdata[NI-1:0];
      if (reg_addr == `EFIRC_A_MSKL) counter_mask_low_q <= reg_wdata;
      if (reg_addr == `EFIRC_A_MSKH) counter_mask_high_q <= reg_wdata;
    end
  end
  assign all_off_full = &(ring_disabled | ring_full);
  assign all_unusable = &(ring_disabled | ring_full | ring_too_small);

  // Events that set status bits this cycle
  always_comb begin
    set = '0;
    set[`EFIRC_I_RXDOVF] = rx_data_ovf;
    set[`EFIRC_I_RXSOVF] = rx_sts_ovf;
    set[`EFIRC_I_RXCLS] = rx_buf_closed;
    set[`EFIRC_I_POOLA +: 4] = rx_frame_done ? pool_dec(rx_frame_pool)
                                             : 4'h0;
    set[`EFIRC_I_NOBUF] = rx_buf_search_fail && all_unusable;
    set[`EFIRC_I_RXFULL] = rx_buf_search_fail && all_off_full;
    set[`EFIRC_I_RXRDY] = rx_frame_avail;
    set[`EFIRC_I_STOVF] = |(stat_ovf &
      ~{counter_mask_high_q, counter_mask_low_q});
    set[`EFIRC_I_TXCLS] = tx_buf_closed;
    set[`EFIRC_I_TXNRDY] = tx_desc_fetch && tx_frame_active &&
                           !tx_desc_hw_ready;
    set[`EFIRC_I_TXDONE] = tx_frame_end && tx_frame_ok;
    set[`EFIRC_I_TX_FAILURE_STATUS] = tx_frame_end && !tx_frame_ok;
    set[`EFIRC_I_TX_NO_FRAME_STATUS] = tx_no_frame;
  end
  // Write-one-to-clear; a new event in the same cycle wins
  assign clr = wr_sts ? reg_wdata[NI-1:0] : '0;
  assign sts_d = (sts_q & ~clr) | set;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) sts_q <= '0;
    else sts_q <= sts_d;
  end

  // Interrupt lines, one per group
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      rx_irq <= |(sts_q & en_q & `EFIRC_RX_GRP);
      tx_irq <= |(sts_q & en_q & `EFIRC_TX_GRP);
    end
  end

  // Transmit halt until software raises the restart bit
  assign restart_rise = tx_logic_restart_toggle_q && !restart_prev_q;
  always_comb begin
    tx_st_d = tx_st_q;
    unique case (tx_st_q)
      EFIRC_TX_RUN: begin
        if ((tx_frame_end && !tx_frame_ok) || tx_no_frame)
          tx_st_d = EFIRC_TX_HALT;
      end
      EFIRC_TX_HALT: begin
        // A new failure beats a restart in the same cycle
        if (restart_rise && !set[`EFIRC_I_TX_FAILURE_STATUS] && !tx_no_frame)
          tx_st_d = EFIRC_TX_RUN;
      end
      default: tx_st_d = EFIRC_TX_RUN;
    endcase
    if (!transmit_path_reset_n_q) tx_st_d = EFIRC_TX_RUN;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_st_q <= EFIRC_TX_RUN;
      restart_prev_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      restart_prev_q <= tx_logic_restart_toggle_q;
    end
  end
  assign tx_halted = tx_st_q == EFIRC_TX_HALT;
  // Per-module reset outputs, registered
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_rd_rst <= 1'b1;
      rx_wr_rst <= 1'b1;
      tx_rd_rst <= 1'b1;
      tx_wr_rst <= 1'b1;
      mac_core_rst <= 1'b1;
      mac_prog_rst <= 1'b0;
      stat_rst <= 1'b0;
      rmii_rst <= 1'b1;
      mac_rx_rst <= 1'b0;
      mac_txcs_rst <= 1'b0;
      mac_tx_rst <= 1'b0;
      miim_rst <= 1'b0;
    end else begin
      rx_rd_rst <= !receive_path_reset_n_q;
      rx_wr_rst <= !receive_path_reset_n_q || mac_hard_reset_q ||
                   mac_soft_reset_q;
      tx_rd_rst <= !transmit_path_reset_n_q || mac_hard_reset_q ||
                   mac_soft_reset_q;
      tx_wr_rst <= !transmit_path_reset_n_q;
      mac_core_rst <= mac_hard_reset_q || mac_soft_reset_q;
      mac_prog_rst <= mac_hard_reset_q;
      stat_rst <= mac_hard_reset_q;
      rmii_rst <= mac_hard_reset_q || mac_soft_reset_q ||
                  reduced_phy_adapter_reset_q;
      mac_rx_rst <= mac_rx_function_reset_q;
      mac_txcs_rst <= mac_tx_control_frame_reset_q;
      mac_tx_rst <= mac_tx_function_reset_q;
      miim_rst <= mgmt_serial_reset_q;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) reg_rdata <= '0;
    else if (!reg_rd) reg_rdata <= '0;
    else begin
      reg_rdata <= '0;
      case (reg_addr)
        `EFIRC_A_CTRL: reg_rdata[3:0] <= {tx_logic_restart_toggle_q,
          mac_hard_reset_q, transmit_path_reset_n_q,
          receive_path_reset_n_q};
        `EFIRC_A_MACC: reg_rdata[5:0] <= {reduced_phy_adapter_reset_q,
          mgmt_serial_reset_q, mac_tx_function_reset_q,
          mac_tx_control_frame_reset_q, mac_rx_function_reset_q,
          mac_soft_reset_q};
        `EFIRC_A_STS: reg_rdata[NI-1:0] <= sts_q;
        `EFIRC_A_EN: reg_rdata[NI-1:0] <= en_q;
        `EFIRC_A_MSKL: reg_rdata <= counter_mask_low_q;
        `EFIRC_A_MSKH: reg_rdata <= counter_mask_high_q;
        `EFIRC_A_TXST: reg_rdata[0] <= tx_halted;
        default: reg_rdata <= '0;
      endcase
    end
  end

  property p_rx_irq_on;
    @(posedge mclk) disable iff (!resetn)
    |(sts_q & en_q & `EFIRC_RX_GRP) |=> rx_irq;
  endproperty
  a_rx_irq_on: assert property (p_rx_irq_on)
    else $error("rx_irq low with enabled receive status");
  property p_tx_irq_off;
    @(posedge mclk) disable iff (!resetn)
    (sts_q & en_q & `EFIRC_TX_GRP) == '0 |=> !tx_irq;
  endproperty
  a_tx_irq_off: assert property (p_tx_irq_off)
    else $error("tx_irq high with no enabled transmit status");
  property p_pool;
    @(posedge mclk) disable iff (!resetn)
    rx_frame_done |=> sts_q[`EFIRC_I_POOLA + $past(rx_frame_pool)];
  endproperty
  a_pool: assert property (p_pool)
    else $error("pool complete bit not set");
  property p_rx_closed;
    @(posedge mclk) disable iff (!resetn)
    rx_buf_closed ##1 !wr_sts [*2] |-> sts_q[`EFIRC_I_RXCLS];
  endproperty
  a_rx_closed: assert property (p_rx_closed)
    else $error("receive buffer closed not held");
  property p_nobuf;
    @(posedge mclk) disable iff (!resetn)
    rx_buf_search_fail && &(ring_disabled | ring_full | ring_too_small)
      |=> sts_q[`EFIRC_I_NOBUF];
  endproperty
  a_nobuf: assert property (p_nobuf)
    else $error("no receive buffer not flagged");
  property p_full;
    @(posedge mclk) disable iff (!resetn)
    rx_buf_search_fail && &(ring_disabled | ring_full)
      |=> sts_q[`EFIRC_I_RXFULL] && sts_q[`EFIRC_I_NOBUF];
  endproperty
  a_full: assert property (p_full)
    else $error("receive buffers full not flagged");
  property p_w1c;
    @(posedge mclk) disable iff (!resetn)
    wr_sts |=> (sts_q & $past(reg_wdata[NI-1:0]) & ~$past(set)) == '0;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("status bit survived write of one");
  property p_w0_keep;
    @(posedge mclk) disable iff (!resetn)
    wr_sts |=> ($past(sts_q) & ~$past(reg_wdata[NI-1:0]) & ~sts_q) == '0;
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("status bit lost on write of zero");
  property p_tx_fail;
    @(posedge mclk) disable iff (!resetn)
    tx_frame_end && !tx_frame_ok && transmit_path_reset_n_q
      |=> tx_halted && sts_q[`EFIRC_I_TX_FAILURE_STATUS] &&
          !$rose(sts_q[`EFIRC_I_TXDONE]);
  endproperty
  a_tx_fail: assert property (p_tx_fail)
    else $error("transmit failure did not halt");
  property p_halt_hold;
    @(posedge mclk) disable iff (!resetn)
    tx_halted && !restart_rise && transmit_path_reset_n_q |=> tx_halted;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("transmit left halt without restart");
  property p_soft;
    @(posedge mclk) disable iff (!resetn)
    mac_soft_reset_q && !mac_hard_reset_q
      |=> mac_core_rst && rmii_rst && !mac_prog_rst;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset distribution wrong");
  property p_path;
    @(posedge mclk) disable iff (!resetn)
    !receive_path_reset_n_q |=> rx_rd_rst && rx_wr_rst;
  endproperty
  a_path: assert property (p_path)
    else $error("receive path reset not applied");
endmodule : efirc_top

// >>> hw/efirc_regs.svh
// Register offsets, field positions and reset values of the
// Ethernet front-end interrupt and reset controller.
// Assumes an 8-bit byte address on the register port.
`ifndef EFIRC_REGS_SVH
`define EFIRC_REGS_SVH
`define EFIRC_A_CTRL 8'h00
`define EFIRC_A_MACC 8'h04
`define EFIRC_A_STS 8'h08
`define EFIRC_A_EN 8'h0C
`define EFIRC_A_MSKL 8'h10
`define EFIRC_A_MSKH 8'h14
`define EFIRC_A_TXST 8'h18
// Control word fields
`define EFIRC_B_ERX 0
`define EFIRC_B_ETX 1
`define EFIRC_B_HRST 2
`define EFIRC_B_TCLR 3
// MAC reset word fields
`define EFIRC_B_MAC_SOFT_RESET 0
`define EFIRC_B_RXF 1
`define EFIRC_B_TCS 2
`define EFIRC_B_TXF 3
`define EFIRC_B_MIIM 4
`define EFIRC_B_RMII 5
`define EFIRC_CTRL_RST 4'h0
`define EFIRC_MACC_RST 6'h01
// Interrupt status / enable fields
`define EFIRC_NI 16
`define EFIRC_I_RXDOVF 0
`define EFIRC_I_RXSOVF 1
`define EFIRC_I_RXCLS 2
`define EFIRC_I_POOLA 3
`define EFIRC_I_NOBUF 7
`define EFIRC_I_RXFULL 8
`define EFIRC_I_RXRDY 9
`define EFIRC_I_STOVF 10
`define EFIRC_I_TXCLS 11
`define EFIRC_I_TXNRDY 12
`define EFIRC_I_TXDONE 13
`define EFIRC_I_TX_FAILURE_STATUS 14
`define EFIRC_I_TX_NO_FRAME_STATUS 15
`define EFIRC_RX_GRP 16'h03FF
`define EFIRC_TX_GRP 16'hFC00
`endif

// >>> hw/efirc_pkg.sv
// Types shared by the interrupt and reset controller.
// Assumes nothing beyond a SystemVerilog compiler.
package efirc_pkg;
  typedef enum logic [1:0] {
    EFIRC_TX_RUN = 2'b01,
    EFIRC_TX_HALT = 2'b10
  } efirc_tx_state_t;
endpackage : efirc_pkg

// >>> tb/efirc_irq_sink.sv
// System interrupt controller model: counts each assertion of the
// receive and transmit interrupt lines on its own counter.
// Assumes both lines are synchronous to mclk.
`timescale 1ns/1ps
module efirc_irq_sink (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic rx_irq,
  input wire logic tx_irq,
  output logic [7:0] rx_cnt_q,
  output logic [7:0] tx_cnt_q
);
  logic rx_q;
  logic tx_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_q <= 1'b0;
      tx_q <= 1'b0;
      rx_cnt_q <= 8'h00;
      tx_cnt_q <= 8'h00;
    end else begin
      rx_q <= rx_irq;
      tx_q <= tx_irq;
      // Two lines, two separate counters
      if (rx_irq && !rx_q) rx_cnt_q <= rx_cnt_q + 8'h01;
      if (tx_irq && !tx_q) tx_cnt_q <= tx_cnt_q + 8'h01;
    end
  end
endmodule : efirc_irq_sink

// >>> tb/efirc_top_test.sv
// Self-checking bench for the interrupt and reset controller.
// Assumes the register port of efirc_top and its header offsets.
`timescale 1ns/1ps
`include "efirc_regs.svh"
module efirc_top_test;
  logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic rx_data_ovf = 0, rx_sts_ovf = 0, rx_buf_closed = 0;
  logic rx_frame_done = 0, rx_buf_search_fail = 0, rx_frame_avail = 0;
  logic [1:0] rx_frame_pool = 2'h0;
  logic [3:0] ring_disabled = 0, ring_full = 0, ring_too_small = 0;
  logic [63:0] stat_ovf = 64'h0;
  logic tx_buf_closed = 0, tx_desc_fetch = 0, tx_frame_active = 0;
  logic tx_desc_hw_ready = 0, tx_frame_end = 0, tx_frame_ok = 0;
  logic tx_no_frame = 0, rx_irq, tx_irq, tx_halted, rd_d = 1'b0;
  logic [11:0] rvec;
  logic [7:0] rx_cnt, tx_cnt;
  logic [31:0] expq[$];
  int num_errors = 0, checked = 0;

  efirc_top efirc_top_inst (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_data_ovf(rx_data_ovf),
    .rx_sts_ovf(rx_sts_ovf), .rx_buf_closed(rx_buf_closed),
    .rx_frame_done(rx_frame_done), .rx_frame_pool(rx_frame_pool),
    .rx_buf_search_fail(rx_buf_search_fail), .ring_disabled(ring_disabled),
    .ring_full(ring_full), .ring_too_small(ring_too_small),
    .rx_frame_avail(rx_frame_avail), .stat_ovf(stat_ovf),
    .tx_buf_closed(tx_buf_closed), .tx_desc_fetch(tx_desc_fetch),
    .tx_frame_active(tx_frame_active), .tx_desc_hw_ready(tx_desc_hw_ready),
    .tx_frame_end(tx_frame_end), .tx_frame_ok(tx_frame_ok),
    .tx_no_frame(tx_no_frame), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .tx_halted(tx_halted), .rx_rd_rst(rvec[11]), .rx_wr_rst(rvec[10]),
    .tx_rd_rst(rvec[9]), .tx_wr_rst(rvec[8]), .mac_core_rst(rvec[7]),
    .mac_prog_rst(rvec[6]), .stat_rst(rvec[5]), .rmii_rst(rvec[4]),
    .mac_rx_rst(rvec[3]), .mac_txcs_rst(rvec[2]), .mac_tx_rst(rvec[1]),
    .miim_rst(rvec[0]));

  efirc_irq_sink efirc_irq_sink_inst (.mclk(mclk), .resetn(resetn),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .rx_cnt_q(rx_cnt), .tx_cnt_q(tx_cnt));

  always #5 mclk = ~mclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back(x);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) rd_d <= reg_rd;
  always @(negedge mclk) begin
    if (rd_d === 1'b1) chk(reg_rdata, expq.pop_front());
    else if (reg_rdata !== 32'h0) chk(reg_rdata, 32'h0);
  end

  function automatic logic [11:0] rexp(input logic [2:0] c,
                                       input logic [5:0] m);
    logic h;
    logic s;
    h = c[2];
    s = m[0];
    return {~c[0], ~c[0] | h | s, ~c[1] | h | s, ~c[1], h | s, h, h,
            h | s | m[5], m[1], m[2], m[3], m[4]};
  endfunction : rexp

  // One event pulse per code; codes 16..18 set nothing while counter_mask_low_q is all ones
  task automatic ev(input int k);
    @(posedge mclk);
    case (k)
      0: rx_data_ovf <= 1'b1;
      1: rx_sts_ovf <= 1'b1;
      2: rx_buf_closed <= 1'b1;
      3, 4, 5, 6: begin
        rx_frame_done <= 1'b1;
        rx_frame_pool <= 2'(k - 3);
      end
      7, 8, 16: begin
        rx_buf_search_fail <= 1'b1;
        ring_too_small <= (k == 7) ? 4'hF : 4'h0;
        ring_full <= (k == 8) ? 4'hF : 4'h0;
        ring_disabled <= (k == 16) ? 4'h7 : 4'h0;
      end
      9: rx_frame_avail <= 1'b1;
      10: stat_ovf <= 64'h1 << (32 + $urandom % 32);
      18: stat_ovf <= 64'h1 << ($urandom % 32);
      11: tx_buf_closed <= 1'b1;
      12, 17: begin
        tx_desc_fetch <= 1'b1;
        tx_frame_active <= 1'b1;
        tx_desc_hw_ready <= (k == 17);
      end
      13, 14: begin
        tx_frame_end <= 1'b1;
        tx_frame_ok <= (k == 13);
      end
      default: tx_no_frame <= 1'b1;
    endcase
    @(posedge mclk);
    {rx_data_ovf, rx_sts_ovf, rx_buf_closed, rx_frame_done} <= 4'h0;
    {rx_buf_search_fail, rx_frame_avail, tx_buf_closed} <= 3'h0;
    {tx_desc_fetch, tx_frame_end, tx_no_frame} <= 3'h0;
    stat_ovf <= 64'h0;
  endtask : ev

  initial begin
    #300000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [15:0] e;
    logic [2:0] c;
    logic [5:0] m;
    void'($urandom(32'h8C81));
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk(32'(rvec), 32'(rexp(3'h0, 6'h01)));
    rd(`EFIRC_A_CTRL, 32'h0);
    rd(`EFIRC_A_MACC, 32'h1);
    rd(`EFIRC_A_STS, 32'h0);
    rd(`EFIRC_A_EN, 32'h0);
    rd(8'h40, 32'h0);
    wr(`EFIRC_A_CTRL, 32'hB);
    wr(`EFIRC_A_MACC, 32'h0);
    wr(`EFIRC_A_EN, 32'hFFFF);
    wr(`EFIRC_A_MSKL, 32'hFFFFFFFF);
    wr(`EFIRC_A_MSKH, 32'h0);
    rd(`EFIRC_A_EN, 32'hFFFF);
    rd(`EFIRC_A_MSKL, 32'hFFFFFFFF);
    rd(`EFIRC_A_MSKH, 32'h0);
    for (int k = 0; k < 19; k++) begin
      e = (k == 8) ? 16'h0180 : ((k < 16) ? 16'h1 << k : 16'h0);
      ev(k);
      repeat (2) @(posedge mclk);
      #1;
      chk(32'({rx_irq, tx_irq}), 32'({|(e & `EFIRC_RX_GRP),
          |(e & `EFIRC_TX_GRP)}));
      rd(`EFIRC_A_STS, {16'h0, e});
      wr(`EFIRC_A_STS, {16'h0, e});
      @(posedge mclk);
      #1;
      chk(32'({rx_irq, tx_irq}), 32'h0);
      if (k == 0) begin
        wr(`EFIRC_A_CTRL, 32'hA);
        @(posedge mclk);
        #1;
        chk(32'(rvec[11:10]), 32'h3);
        wr(`EFIRC_A_CTRL, 32'hB);
      end
      if (k == 14 || k == 15) begin
        rd(`EFIRC_A_TXST, 32'h1);
        wr(`EFIRC_A_CTRL, 32'h3);
        wr(`EFIRC_A_CTRL, 32'hB);
        repeat (2) @(posedge mclk);
        #1;
        chk(32'(tx_halted), 32'h0);
      end
    end
    chk(32'({rx_cnt, tx_cnt}), 32'h0A06);
    wr(`EFIRC_A_EN, 32'h0);
    wr(`EFIRC_A_MSKL, 32'h0);
    wr(`EFIRC_A_MSKH, 32'hFFFFFFFF);
    ev(10);
    rd(`EFIRC_A_STS, 32'h0);
    ev(18);
    rd(`EFIRC_A_STS, 32'h0400);
    wr(`EFIRC_A_STS, 32'h0400);
    ev(11);
    wr(`EFIRC_A_STS, 32'h0);
    rd(`EFIRC_A_STS, 32'h0800);
    #1;
    chk(32'(tx_irq), 32'h0);
    wr(`EFIRC_A_EN, 32'h0800);
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(tx_irq), 32'h1);
    wr(`EFIRC_A_STS, 32'h0800);
    for (int i = 0; i < 8; i++) begin
      c = 3'($urandom);
      m = 6'($urandom);
      wr(`EFIRC_A_CTRL, {28'h0, 1'b1, c});
      wr(`EFIRC_A_MACC, {26'h0, m});
      @(posedge mclk);
      #1;
      chk(32'(rvec), 32'(rexp(c, m)));
    end
    wr(`EFIRC_A_CTRL, 32'hF);
    @(posedge mclk);
    #1;
    chk(32'(rvec), 32'(rexp(3'h7, m)));
    report_and_stop();
  end
endmodule : efirc_top_test
